//--- verilog/pfb_pkg.sv
// Purpose: Shared constants and types for the parallel flash bus host sequencer.
// Assumes: System clock of 10 MHz (100 ns period).
// Notes: Times are kept in their printed unit; cycle counts derive from them.
package pfb_pkg;
  // ==========================================================================
  // Clock and timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_STANDBY_US = 20;
  localparam int T_READY_ALG_US = 20;
  localparam int T_READY_IDLE_NS = 500;
  localparam int T_RESET_HIGH_NS = 50;
  localparam int T_OE_HIGH_POLL_NS = 20;
  localparam int T_BUSY_NS = 90;
  localparam int T_PROG_BYTE_US = 5;
  localparam int T_PROG_WORD_US = 7;
  localparam int T_PROG_ACC_US = 4;
  localparam int T_POLL_TIMEOUT_US = 5000000;
  // Least times round up, longest times round down, never under one cycle.
  localparam int RST_LOW_CYC = (T_STANDBY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_RECOV_CYC = (T_RESET_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_ALG_CYC = (T_READY_ALG_US * 1000) / CLK_PERIOD_NS;
  localparam int OE_HIGH_CYC = (T_OE_HIGH_POLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CYC_RAW = T_BUSY_NS / CLK_PERIOD_NS;
  localparam int BUSY_CYC = (BUSY_CYC_RAW < 1) ? 1 : BUSY_CYC_RAW;
  localparam int STROBE_CYC = 1;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  // Toggle status bit positions on the data bus.
  localparam int OP_TOGGLE_POS = 6;
  localparam int ES_TOGGLE_POS = 2;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ==========================================================================
  // Commands and states.
  typedef enum logic [1:0] {PFB_CMD_READ, PFB_CMD_WRITE, PFB_CMD_POLL, PFB_CMD_RESET} pfb_cmd_t;
  typedef struct packed {
    pfb_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfb_req_t;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic dq_oe;
  } pfb_pins_t;
endpackage

//--- verilog/pfb_host.sv
// Purpose: Host-side sequencer that drives an asynchronous parallel NOR flash.
// Assumes: One 10 MHz clock; device pins are asynchronous and are synchronised.
// Notes: Runs reset, read, write and toggle-bit status polling cycles.
module pfb_host #(
  parameter int RST_LOW_CYCLES = pfb_pkg::RST_LOW_CYC,
  parameter int POLL_TIMEOUT = 16000000
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire pfb_pkg::pfb_req_t i_req,
  output logic o_req_ready,
  output logic o_done,
  output logic o_timeout,
  output logic [pfb_pkg::DATA_W-1:0] o_rdata,
  output logic o_busy,
  output logic [pfb_pkg::ADDR_W-1:0] o_flash_addr,
  output logic [pfb_pkg::DATA_W-1:0] o_flash_dq,
  output logic o_flash_dq_oe,
  input wire logic [pfb_pkg::DATA_W-1:0] i_flash_dq,
  output logic o_flash_cs_n,
  output logic o_flash_oe_n,
  output logic o_flash_we_n,
  output logic o_flash_rst_n,
  input wire logic i_ready_busy_out_n
);
  import pfb_pkg::*;

  typedef enum {ST_IDLE, ST_RST_LOW, ST_RST_RECOV, ST_RD, ST_WR, ST_WR_BUSY,
    ST_POLL_RD, ST_POLL_GAP} pfb_state_t;

  // ==========================================================================
  // Input synchronisers.
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  logic rb_meta;
  logic rb_sync;
  pfb_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] poll_cnt;
  logic [DATA_W-1:0] last_status;
  logic have_status;
  pfb_pins_t pins;

  function automatic logic [CNT_W-1:0] to_cnt(input int n);
    to_cnt = CNT_W'(n);
  endfunction

  // Two flops keep metastability away from the status compare.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      dq_meta <= '0;
      dq_sync <= '0;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end
    else if (i_ce)
    begin
      dq_meta <= i_flash_dq;
      dq_sync <= dq_meta;
      rb_meta <= i_ready_busy_out_n;
      rb_sync <= rb_meta;
    end
  end

  // ==========================================================================
  // Sequencer.
  // A read waits for the strobe plus two sync stages, so cnt counts them out.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state <= ST_RST_LOW;
      cnt <= CNT_ZERO;
      poll_cnt <= CNT_ZERO;
      pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, dq_oe: 1'b0};
      o_flash_addr <= '0;
      o_flash_dq <= '0;
      o_rdata <= '0;
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      last_status <= '0;
      have_status <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // no recovery delay once ready shows; a write starts at once.
          if (i_req_valid)
          begin
            o_flash_addr <= i_req.addr;
            o_flash_dq <= i_req.data;
            cnt <= CNT_ZERO;
            case (i_req.cmd)
              PFB_CMD_READ:
              begin
                pins <= '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0};
                state <= ST_RD;
              end
              PFB_CMD_WRITE:
              begin
                pins <= '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, rst_n: 1'b1, dq_oe: 1'b1};
                state <= ST_WR;
              end
              PFB_CMD_POLL:
              begin
                pins <= '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0};
                have_status <= 1'b0;
                poll_cnt <= CNT_ZERO;
                state <= ST_POLL_RD;
              end
              default:
              begin
                pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, dq_oe: 1'b0};
                state <= ST_RST_LOW;
              end
            endcase
          end
        end
        ST_RST_LOW:
        begin
          // Holding reset long enough also covers the abort time of a busy device.
          if (cnt >= to_cnt(RST_LOW_CYCLES - 1))
          begin
            pins.rst_n <= 1'b1;
            cnt <= CNT_ZERO;
            state <= ST_RST_RECOV;
          end
          else
            cnt <= cnt + CNT_ONE;
        end
        ST_RST_RECOV:
        begin
          if (cnt >= to_cnt(RST_RECOV_CYC - 1))
          begin
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
          else
            cnt <= cnt + CNT_ONE;
        end
        ST_RD:
        begin
          if (cnt >= to_cnt(STROBE_CYC + 2))
          begin
            o_rdata <= dq_sync;
            pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0};
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
          else
            cnt <= cnt + CNT_ONE;
        end
        ST_WR:
        begin
          pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0};
          cnt <= CNT_ZERO;
          state <= ST_WR_BUSY;
        end
        ST_WR_BUSY:
        begin
          // Give the device its busy delay before the write is reported done.
          if (cnt >= to_cnt(BUSY_CYC + 2))
          begin
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
          else
            cnt <= cnt + CNT_ONE;
        end
        ST_POLL_RD:
        begin
          if (cnt >= to_cnt(STROBE_CYC + 2))
          begin
            // the read strobe and chip select are both raised between reads.
            pins.oe_n <= 1'b1;
            pins.cs_n <= 1'b1;
            last_status <= dq_sync;
            have_status <= 1'b1;
            cnt <= CNT_ZERO;
            poll_cnt <= poll_cnt + CNT_ONE;
            // finish when the toggle bit stops or ready shows.
            if ((have_status && (last_status[OP_TOGGLE_POS] == dq_sync[OP_TOGGLE_POS]))
                || rb_sync)
            begin
              o_rdata <= dq_sync;
              o_done <= 1'b1;
              state <= ST_IDLE;
            end
            else if (poll_cnt >= to_cnt(POLL_TIMEOUT - 1))
            begin
              o_timeout <= 1'b1;
              o_done <= 1'b1;
              state <= ST_IDLE;
            end
            else
              state <= ST_POLL_GAP;
          end
          else
            cnt <= cnt + CNT_ONE;
        end
        ST_POLL_GAP:
        begin
          if (cnt >= to_cnt(OE_HIGH_CYC - 1))
          begin
            pins.oe_n <= 1'b0;
            pins.cs_n <= 1'b0;
            cnt <= CNT_ZERO;
            state <= ST_POLL_RD;
          end
          else
            cnt <= cnt + CNT_ONE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pin and status outputs.
  assign o_flash_cs_n = pins.cs_n;
  assign o_flash_oe_n = pins.oe_n;
  assign o_flash_we_n = pins.we_n;
  assign o_flash_rst_n = pins.rst_n;
  assign o_flash_dq_oe = pins.dq_oe;
  assign o_req_ready = (state == ST_IDLE);
  assign o_busy = ~rb_sync;

  // ==========================================================================
  // Assertions.
  int unsigned rst_low_len;
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      rst_low_len <= 0;
    else if (i_ce)
      rst_low_len <= pins.rst_n ? 0 : rst_low_len + 1;
  end

  AST_RST_LOW_LEN: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ($rose(pins.rst_n) |-> $past(rst_low_len) >= RST_LOW_CYCLES - 1))
    else $error("Flash reset released too early.");
  AST_RST_RECOV: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ($fell(pins.oe_n) |-> $past(pins.rst_n) && $past(pins.rst_n, 2)))
    else $error("Read started right at reset release.");
  AST_POLL_GAP: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ($fell(pins.oe_n) && (state == ST_POLL_RD) && ($past(state) != ST_IDLE)
      |-> ($past(state) == ST_POLL_GAP)))
    else $error("Read strobe high too short between polls.");
  AST_CE_FREEZE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (!i_ce |=> $stable(state) && $stable(pins) && $stable(cnt)))
    else $error("Sequencer moved while the clock enable was low.");
  AST_POLL_TOGGLE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ((state == ST_POLL_GAP) |-> pins.oe_n && pins.cs_n))
    else $error("Strobes not raised between status reads.");
  AST_POLL_END: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ($fell(o_req_ready) && (state == ST_POLL_RD) |-> !o_done))
    else $error("Poll reported done before any status read.");
  AST_WR_IMMEDIATE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (o_req_ready && i_req_valid && i_ce && (i_req.cmd == PFB_CMD_WRITE) |=> !pins.we_n))
    else $error("Write not started at once.");
  AST_WR_PULSE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ((state == ST_WR) && i_ce |=> pins.we_n && (state == ST_WR_BUSY)))
    else $error("Write pulse not ended after one cycle.");
  AST_DQ_DRIVE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (pins.dq_oe |-> !pins.we_n && pins.oe_n))
    else $error("Data bus driven outside a write.");

  COV_RESET: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) $rose(pins.rst_n));
  COV_READ: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state == ST_RD) ##1 (state == ST_IDLE));
  COV_POLL: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (state == ST_POLL_GAP) ##[1:20] (state == ST_POLL_RD));
  COV_TIMEOUT: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) o_timeout);
endmodule

//--- verif/pfb_flash_model.sv
// Purpose: Behavioural flash device facing the host sequencer.
// Assumes: Busy time is given in host clock cycles by the bench.
// Notes: Data lines not driven by the device show the inverse of the last value.
module pfb_flash_model #(
  parameter logic [5:0] SUSP_SECT = 6'h2a
) (
  input wire logic i_clk,
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_rst_n,
  input wire logic i_dq_oe,
  input wire logic [pfb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pfb_pkg::DATA_W-1:0] i_dq,
  input wire logic [15:0] i_busy_cycles,
  output logic [pfb_pkg::DATA_W-1:0] o_dq,
  output logic o_ready_busy_n,
  output logic [pfb_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [pfb_pkg::DATA_W-1:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfb_pkg::*;
  logic [15:0] busy_cnt = 16'h0000;
  logic bank = 1'b0;
  logic tog6 = 1'b0;
  logic tog2 = 1'b0;
  logic [DATA_W-1:0] last = 16'h0000;
  logic [DATA_W-1:0] val;
  logic rd_act;
  // ==========================================================================
  // Algorithm timing.
  // A write strobe starts the algorithm; a low reset aborts it at once.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_cnt <= 16'h0000;
    else if (!i_cs_n && !i_we_n && i_dq_oe && busy_cnt == 16'h0000)
    begin
      busy_cnt <= i_busy_cycles;
      bank <= i_addr[ADDR_W-1];
      o_wr_addr <= i_addr;
      o_wr_data <= i_dq;
    end
    else if (busy_cnt != 16'h0000)
      busy_cnt <= busy_cnt - 16'h0001;
  end
  assign rd_act = !i_cs_n && !i_oe_n && i_rst_n;
  // Bit 6 flips when either strobe ends a read, as the host may use either; bit 2 flips only in sector SUSP_SECT.
  always @(negedge rd_act)
  begin
    if (busy_cnt != 16'h0000)
    begin
      tog6 <= !tog6;
      if (i_addr[ADDR_W-1:ADDR_W-6] == SUSP_SECT)
        tog2 <= !tog2;
    end
  end
  // ==========================================================================
  // Read path.
  // The idle bank reads array data even while the other bank is busy.
  always_comb
  begin
    val = i_addr[DATA_W-1:0] ^ 16'ha5c3;
    if (busy_cnt != 16'h0000 && i_addr[ADDR_W-1] == bank)
    begin
      val = 16'h0000;
      val[OP_TOGGLE_POS] = tog6;
      val[ES_TOGGLE_POS] = tog2;
    end
  end
  always @(posedge i_clk)
  begin
    if (rd_act)
      last <= val;
  end
  assign o_dq = rd_act ? val : ~last;
  assign o_ready_busy_n = (busy_cnt == 16'h0000);
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the flash host sequencer.
// Assumes: 10 MHz clock; inputs change on the falling edge.
// Notes: Short reset and poll limits keep the run brief.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pfb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  pfb_req_t req = '0;
  logic ready, done, tmo, busy, dq_oe, cs_n, oe_n, we_n, frst_n, rb_n, oe_q;
  logic [DATA_W-1:0] rdata, fdq, mdq, wr_data, d;
  logic [ADDR_W-1:0] faddr, wr_addr, a;
  logic [15:0] busy_cycles = 16'h0020;
  logic [15:0] lf = 16'h1b2f;
  logic [15:0] lc = 16'h1b2f;
  logic ce = 1'b1;
  logic freeze = 1'b0;
  int err_total = 0, checks = 0, cyc = 0, reads = 0, hi_cnt = 0, low_cnt = 0, rec_cnt = 0;
  always #50 clk = ~clk;
  pfb_host #(.RST_LOW_CYCLES(4), .POLL_TIMEOUT(400)) i_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .i_ce(ce), .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready), .o_done(done),
    .o_timeout(tmo), .o_rdata(rdata), .o_busy(busy), .o_flash_addr(faddr), .o_flash_dq(fdq),
    .o_flash_dq_oe(dq_oe), .i_flash_dq(mdq), .o_flash_cs_n(cs_n), .o_flash_oe_n(oe_n),
    .o_flash_we_n(we_n), .o_flash_rst_n(frst_n), .i_ready_busy_out_n(rb_n));
  pfb_flash_model i_dev (.i_clk(clk), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_rst_n(frst_n), .i_dq_oe(dq_oe), .i_addr(faddr), .i_dq(fdq), .i_busy_cycles(busy_cycles),
    .o_dq(mdq), .o_ready_busy_n(rb_n), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  // ==========================================================================
  // Helpers.
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] x);
    return x[DATA_W-1:0] ^ 16'ha5c3;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded waits, so a stuck sequencer shows as a mismatch.
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    check(done, 1'b1);
  endtask
  task automatic op(input pfb_cmd_t c, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
    int n;
    @(negedge clk);
    n = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req = '{c, ad, dt};
    // Hold the request until an edge with the enable high has taken it.
    do
      @(negedge clk);
    while (ce !== 1'b1);
    req_valid = 1'b0;
    reads = 0;
    wait_done();
  endtask
  // ==========================================================================
  // Pin monitor: reset pulse length, recovery and strobe high time between reads.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
    if (frst_n === 1'b1 && low_cnt != 0)
      check(low_cnt >= 4, 1'b1);
    if (oe_q === 1'b1 && oe_n === 1'b0)
    begin
      reads++;
      check(hi_cnt >= OE_HIGH_CYC, 1'b1);
      check(rec_cnt >= RST_RECOV_CYC, 1'b1);
    end
    low_cnt <= (frst_n === 1'b0 && !rst) ? low_cnt + 1 : 0;
    rec_cnt <= (frst_n === 1'b1) ? rec_cnt + 1 : 0;
    hi_cnt <= (oe_n === 1'b1) ? hi_cnt + 1 : 0;
    oe_q <= oe_n;
  end
  // Clock enable drops at random only while freeze is set, so that the tight
  // busy margins of the ordinary scenarios are not stretched.
  always @(negedge clk)
  begin
    lc <= nxt(lc);
    ce <= !freeze || (lc[1:0] != 2'h0);
  end
  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    wait_done();
    for (int i = 0; i < 6; i++)
    begin
      lf = nxt(lf);
      a = {lf[15:10], lf};
      lf = nxt(lf);
      d = lf;
      busy_cycles = 16'h0014 + {10'h000, lf[5:0]};
      op(PFB_CMD_WRITE, a, d);
      check(wr_addr, a);
      check(wr_data, d);
      check(busy, 1'b1);
      op(PFB_CMD_READ, a ^ 22'h200000, 16'h0000);
      check(rdata, exp_rd(a ^ 22'h200000));
      op(PFB_CMD_POLL, a, 16'h0000);
      check(reads >= 2, 1'b1);
      check(tmo, 1'b0);
      check(rb_n, 1'b1);
    end
    busy_cycles = 16'h1770;
    op(PFB_CMD_WRITE, 22'h0abcde, 16'h1234);
    freeze = 1'b1;
    op(PFB_CMD_POLL, 22'h0abcde, 16'h0000);
    check(tmo, 1'b1);
    freeze = 1'b0;
    op(PFB_CMD_RESET, 22'h000000, 16'h0000);
    check(rb_n, 1'b1);
    op(PFB_CMD_READ, 22'h0abcde, 16'h0000);
    check(rdata, exp_rd(22'h0abcde));
    conclude();
  end
endmodule
